/* hdl/pfcs_pkg.sv */
// Types for the port 2 flow control register block
package pfcs_pkg;

    typedef enum logic [0:0] {
        PFCS_IDLE = 1'h0,
        PFCS_RESP = 1'h1
    } pfcs_apb_state_t;

    typedef logic [31:0] pfcs_word_t;

endpackage

/* hdl/pfcs_regs.svh */
// Register map, field positions, reset values and timing counts for port 2 flow control
`ifndef PFCS_REGS_SVH
`define PFCS_REGS_SVH

`define PFCS_ADDR_W 12
`define PFCS_ADDR_FC_CFG 12'h1A4

`define PFCS_BIT_BACKPRESSURE 6
`define PFCS_BIT_DUPLEX 5
`define PFCS_BIT_CUR_RX 4
`define PFCS_BIT_CUR_TX 3
`define PFCS_BIT_RX_EN 2
`define PFCS_BIT_TX_EN 1
`define PFCS_BIT_MANUAL 0
`define PFCS_RSVD_MSB 31
`define PFCS_RSVD_LSB 7

`define PFCS_RST_FIELD 1'h0
`define PFCS_RST_WORD 32'h0000_0000

// Edges after reset release before the strap synchronisers hold valid levels
`define PFCS_STRAP_SETTLE 2'h2
`define PFCS_SETTLE_DONE 2'h3

`endif

/* hdl/pfcs_top.sv */
// Port 2 flow control configuration and status register with APB slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "pfcs_regs.svh"

module pfcs_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PFCS_ADDR_W-1:0] paddr,
    input wire pfcs_pkg::pfcs_word_t pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration straps, pins
    input wire logic backpressure_strap,
    input wire logic full_duplex_pause_strap,
    input wire logic manual_select_strap,
    input wire logic an_enable_strap,
    input wire logic full_duplex_strap,
    // Negotiated results from the PHY, pins
    input wire logic an_full_duplex,
    input wire logic an_rx_pause,
    input wire logic an_tx_pause,
    // Loader rewrite of straps, same clock
    input wire logic eeprom_reload,
    input wire logic eeprom_backpressure,
    input wire logic eeprom_pause,
    input wire logic eeprom_manual,
    input wire logic eeprom_an_enable,
    input wire logic eeprom_full_duplex,
    // Effective flow control to the port
    output logic port_backpressure_en,
    output logic port_rx_pause_en,
    output logic port_tx_pause_en,
    output logic port_half_duplex
);
    import pfcs_pkg::*;

    localparam int SYNC_W = 8;

    pfcs_apb_state_t state_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [1:0] settle_q;
    logic strap_load;
    logic backpressure_enable_q;
    logic rx_pause_enable_q;
    logic tx_pause_enable_q;
    logic manual_pause_select_q;
    logic an_enable_q;
    logic forced_full_duplex_q;
    logic actual_duplex_status_q;
    logic active_rx_pause_status_q;
    logic active_tx_pause_status_q;
    logic addr_hit;
    logic access;
    logic wr_fire;
    logic full_duplex;
    logic use_manual;
    logic cur_rx_d;
    logic cur_tx_d;
    logic [31:0] rd_word;

    // Pins pass two flops; nothing but the second stage reads the first
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {an_tx_pause, an_rx_pause, an_full_duplex, full_duplex_strap,
                        an_enable_strap, manual_select_strap, full_duplex_pause_strap,
                        backpressure_strap};
            sync2_q <= sync1_q;
        end
    end

    // Straps are caught after release, once the synchronisers have filled
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            settle_q <= 2'h0;
        end else if (settle_q != `PFCS_SETTLE_DONE) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    assign strap_load = (settle_q == `PFCS_STRAP_SETTLE);

    // APB decode
    assign addr_hit = (paddr == `PFCS_ADDR_FC_CFG);
    assign access = psel && penable;
    // Write lands on the edge at which pready is seen high
    assign wr_fire = access && pwrite && addr_hit && (state_q == PFCS_RESP);

    // One wait state keeps read data registered and the output flop-driven
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= PFCS_IDLE;
        end else begin
            case (state_q)
                PFCS_IDLE: begin
                    if (access) begin
                        state_q <= PFCS_RESP;
                    end
                end
                PFCS_RESP: begin
                    state_q <= PFCS_IDLE;
                end
                default: begin
                    state_q <= PFCS_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rd_word = `PFCS_RST_WORD;
        rd_word[`PFCS_BIT_BACKPRESSURE] = backpressure_enable_q;
        rd_word[`PFCS_BIT_DUPLEX] = actual_duplex_status_q;
        rd_word[`PFCS_BIT_CUR_RX] = active_rx_pause_status_q;
        rd_word[`PFCS_BIT_CUR_TX] = active_tx_pause_status_q;
        rd_word[`PFCS_BIT_RX_EN] = rx_pause_enable_q;
        rd_word[`PFCS_BIT_TX_EN] = tx_pause_enable_q;
        rd_word[`PFCS_BIT_MANUAL] = manual_pause_select_q;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= `PFCS_RST_WORD;
            pslverr_q <= 1'h0;
        end else if (access && (state_q == PFCS_IDLE)) begin
            prdata_q <= (addr_hit && !pwrite) ? rd_word : `PFCS_RST_WORD;
            pslverr_q <= !addr_hit;
        end else begin
            prdata_q <= `PFCS_RST_WORD;
            pslverr_q <= 1'h0;
        end
    end

    // Writable fields; a loader rewrite in the same cycle beats a software write.
    // Only this block's own flops change, the PHY advertisement is untouched.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            backpressure_enable_q <= `PFCS_RST_FIELD;
            rx_pause_enable_q <= `PFCS_RST_FIELD;
            tx_pause_enable_q <= `PFCS_RST_FIELD;
            manual_pause_select_q <= `PFCS_RST_FIELD;
        end else if (strap_load) begin
            backpressure_enable_q <= sync2_q[0];
            rx_pause_enable_q <= sync2_q[1];
            tx_pause_enable_q <= sync2_q[1];
            manual_pause_select_q <= sync2_q[2];
        end else if (eeprom_reload) begin
            backpressure_enable_q <= eeprom_backpressure;
            rx_pause_enable_q <= eeprom_pause;
            tx_pause_enable_q <= eeprom_pause;
            manual_pause_select_q <= eeprom_manual;
        end else if (wr_fire) begin
            backpressure_enable_q <= pwdata[`PFCS_BIT_BACKPRESSURE];
            rx_pause_enable_q <= pwdata[`PFCS_BIT_RX_EN];
            tx_pause_enable_q <= pwdata[`PFCS_BIT_TX_EN];
            manual_pause_select_q <= pwdata[`PFCS_BIT_MANUAL];
        end
    end

    // Strap-derived link mode behind the status defaults
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            an_enable_q <= `PFCS_RST_FIELD;
            forced_full_duplex_q <= `PFCS_RST_FIELD;
        end else if (strap_load) begin
            an_enable_q <= sync2_q[3];
            forced_full_duplex_q <= sync2_q[4];
        end else if (eeprom_reload) begin
            an_enable_q <= eeprom_an_enable;
            forced_full_duplex_q <= eeprom_full_duplex;
        end
    end

    assign full_duplex = an_enable_q ? sync2_q[5] : forced_full_duplex_q;
    assign use_manual = manual_pause_select_q || !an_enable_q;

    // Pause only applies in full duplex; half duplex relies on backpressure
    always_comb begin
        cur_rx_d = 1'h0;
        cur_tx_d = 1'h0;
        if (full_duplex) begin
            if (use_manual) begin
                cur_rx_d = rx_pause_enable_q;
                cur_tx_d = tx_pause_enable_q;
            end else begin
                cur_rx_d = sync2_q[6];
                cur_tx_d = sync2_q[7];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            actual_duplex_status_q <= `PFCS_RST_FIELD;
            active_rx_pause_status_q <= `PFCS_RST_FIELD;
            active_tx_pause_status_q <= `PFCS_RST_FIELD;
        end else begin
            actual_duplex_status_q <= !full_duplex;
            active_rx_pause_status_q <= cur_rx_d;
            active_tx_pause_status_q <= cur_tx_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = (state_q == PFCS_RESP);
    assign pslverr = pslverr_q;
    assign port_backpressure_en = backpressure_enable_q;
    assign port_rx_pause_en = active_rx_pause_status_q;
    assign port_tx_pause_en = active_tx_pause_status_q;
    assign port_half_duplex = actual_duplex_status_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    logic rd_ok;
    assign rd_ok = pready && access && !pwrite && addr_hit;

    a_reserved_read_zero: assert property (
        rd_ok |-> prdata[`PFCS_RSVD_MSB:`PFCS_RSVD_LSB] == '0)
        else $error("reserved bits read nonzero");

    // Read data is launched on the same edge that raises pready, so fields are compared one cycle back
    a_read_shows_fields: assert property (
        rd_ok |-> prdata[`PFCS_BIT_MANUAL] == $past(manual_pause_select_q)
            && prdata[`PFCS_BIT_BACKPRESSURE] == $past(backpressure_enable_q))
        else $error("read data differs from fields");

    a_one_wait_state: assert property (
        (access && !pready) |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    a_unmapped_error: assert property (
        (pready && access && !addr_hit) |-> pslverr && prdata == '0)
        else $error("unmapped access not flagged");

    a_idle_bus_zero: assert property (
        !pready |-> prdata == '0 && !pslverr)
        else $error("read bus not quiet outside answer");

    a_write_backpressure: assert property (
        (wr_fire && !eeprom_reload && !strap_load)
        |=> port_backpressure_en == $past(pwdata[`PFCS_BIT_BACKPRESSURE]))
        else $error("backpressure write lost");

    a_write_pause_fields: assert property (
        (wr_fire && !eeprom_reload && !strap_load)
        |=> rx_pause_enable_q == $past(pwdata[`PFCS_BIT_RX_EN])
            && tx_pause_enable_q == $past(pwdata[`PFCS_BIT_TX_EN]))
        else $error("pause enable write lost");

    a_write_manual: assert property (
        (wr_fire && !eeprom_reload && !strap_load)
        |=> manual_pause_select_q == $past(pwdata[`PFCS_BIT_MANUAL]))
        else $error("manual select write lost");

    a_write_refused: assert property (
        (pready && access && pwrite && !addr_hit && !eeprom_reload && !strap_load)
        |=> $stable(backpressure_enable_q) && $stable(manual_pause_select_q)
            && $stable(rx_pause_enable_q) && $stable(tx_pause_enable_q))
        else $error("refused write changed a field");

    a_duplex_status: assert property (
        (an_enable_q && sync2_q[5] && !eeprom_reload) |=> !port_half_duplex)
        else $error("duplex status wrong");

    a_half_no_pause: assert property (
        port_half_duplex |-> !port_rx_pause_en && !port_tx_pause_en)
        else $error("pause active in half duplex");

    a_manual_pause: assert property (
        (full_duplex && manual_pause_select_q)
        |=> port_tx_pause_en == $past(tx_pause_enable_q)
            && port_rx_pause_en == $past(rx_pause_enable_q))
        else $error("manual pause not applied");

    a_autoneg_pause: assert property (
        (full_duplex && !manual_pause_select_q && an_enable_q)
        |=> port_rx_pause_en == $past(sync2_q[6])
            && port_tx_pause_en == $past(sync2_q[7]))
        else $error("negotiated pause not applied");

    a_an_off_pause: assert property (
        (full_duplex && !an_enable_q) |=> port_tx_pause_en == $past(tx_pause_enable_q))
        else $error("forced mode pause not applied");

    a_an_off_rx: assert property (
        (full_duplex && !an_enable_q) |=> port_rx_pause_en == $past(rx_pause_enable_q))
        else $error("forced mode receive pause not applied");

    a_forced_half: assert property (
        (!an_enable_q && !forced_full_duplex_q) |=> port_half_duplex)
        else $error("forced half duplex not reported");

    a_status_readback: assert property (
        rd_ok |-> prdata[`PFCS_BIT_CUR_RX] == $past(port_rx_pause_en)
            && prdata[`PFCS_BIT_CUR_TX] == $past(port_tx_pause_en))
        else $error("status readback mismatch");

    a_strap_latch: assert property (
        strap_load |=> backpressure_enable_q == $past(sync2_q[0])
            && manual_pause_select_q == $past(sync2_q[2]))
        else $error("strap not latched");

    a_strap_pause: assert property (
        strap_load |=> rx_pause_enable_q == $past(sync2_q[1])
            && tx_pause_enable_q == $past(sync2_q[1]))
        else $error("pause strap not latched");

    a_strap_once: assert property (
        strap_load |=> !strap_load [*8])
        else $error("strap latched twice");

    a_reload_fields: assert property (
        (eeprom_reload && !strap_load)
        |=> backpressure_enable_q == $past(eeprom_backpressure)
            && rx_pause_enable_q == $past(eeprom_pause)
            && manual_pause_select_q == $past(eeprom_manual))
        else $error("loader rewrite not applied");

    a_reload_mode: assert property (
        (eeprom_reload && !strap_load)
        |=> an_enable_q == $past(eeprom_an_enable)
            && forced_full_duplex_q == $past(eeprom_full_duplex))
        else $error("loader mode rewrite not applied");

    c_write_done: cover property (wr_fire);
    c_read_done: cover property (rd_ok);
    c_reload_seen: cover property (eeprom_reload ##1 port_rx_pause_en);
    c_unmapped: cover property (pready && pslverr);
    c_forced_pause: cover property (full_duplex && !an_enable_q && !manual_pause_select_q);

endmodule

/* sim/port2_flow_control_select_tb.sv */
// Self-checking bench for the port 2 flow control register block
`timescale 1ns/1ps
`include "pfcs_regs.svh"

module port2_flow_control_select_tb;
    import pfcs_pkg::*;

    typedef struct packed {
        logic [31:0] wd;
        logic fd;
        logic rx;
        logic tx;
        logic [31:0] exp;
    } pfcs_row_t;

    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    pfcs_word_t pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bp_s = 1'h1;
    logic pause_s = 1'h1;
    logic man_s = 1'h0;
    logic an_s = 1'h1;
    logic fd_s = 1'h1;
    logic an_fd = 1'h1;
    logic an_rx = 1'h1;
    logic an_tx = 1'h0;
    logic ld = 1'h0;
    logic [4:0] ld_v = 5'h00;
    logic port_bp;
    logic port_rx;
    logic port_tx;
    logic port_hd;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    pfcs_word_t rd;
    logic err;
    pfcs_row_t rows [5];

    pfcs_top i_pfcs_top (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .backpressure_strap(bp_s),
        .full_duplex_pause_strap(pause_s), .manual_select_strap(man_s),
        .an_enable_strap(an_s), .full_duplex_strap(fd_s), .an_full_duplex(an_fd),
        .an_rx_pause(an_rx), .an_tx_pause(an_tx), .eeprom_reload(ld),
        .eeprom_backpressure(ld_v[4]), .eeprom_pause(ld_v[3]), .eeprom_manual(ld_v[2]),
        .eeprom_an_enable(ld_v[1]), .eeprom_full_duplex(ld_v[0]),
        .port_backpressure_en(port_bp), .port_rx_pause_en(port_rx),
        .port_tx_pause_en(port_tx), .port_half_duplex(port_hd)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A hang anywhere ends the run through the same report
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data and error are taken only at the edge that samples pready high
    task automatic apb(input logic wr, input logic [11:0] a, input pfcs_word_t d,
                       output pfcs_word_t r, output logic e);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Register read plus the port outputs that mirror bits 6 to 3
    task automatic rd_chk(input logic [31:0] exp);
        apb(1'h0, `PFCS_ADDR_FC_CFG, 32'h0, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0);
        chk({28'h0, port_bp, port_hd, port_rx, port_tx}, {28'h0, exp[6:3]});
    endtask

    task automatic reload(input logic [4:0] v);
        @(posedge sys_clk);
        ld <= 1'h1;
        ld_v <= v;
        @(posedge sys_clk);
        ld <= 1'h0;
        repeat (3) @(posedge sys_clk);
    endtask

    initial begin
        rows[0] = '{32'hFFFF_FFFF, 1'h1, 1'h0, 1'h0, 32'h0000_005F};
        rows[1] = '{32'h0000_0005, 1'h1, 1'h0, 1'h0, 32'h0000_0015};
        rows[2] = '{32'h0000_0001, 1'h0, 1'h1, 1'h1, 32'h0000_0021};
        rows[3] = '{32'h0000_0046, 1'h1, 1'h0, 1'h1, 32'h0000_004E};
        rows[4] = '{32'h0000_0000, 1'h1, 1'h1, 1'h1, 32'h0000_0018};
        repeat (8) @(posedge sys_clk);
        chk({23'h0, prdata[3:0], pready, port_bp, port_rx, port_tx, port_hd}, 32'h0);
        resetn <= 1'h1;
        repeat (6) @(posedge sys_clk);
        rd_chk(32'h0000_0056);
        foreach (rows[i]) begin
            an_fd <= rows[i].fd;
            an_rx <= rows[i].rx;
            an_tx <= rows[i].tx;
            apb(1'h1, `PFCS_ADDR_FC_CFG, rows[i].wd, rd, err);
            repeat (4) @(posedge sys_clk);
            rd_chk(rows[i].exp);
        end
        // Unmapped place: refused with an error, register untouched
        apb(1'h1, 12'h1A8, 32'h0000_0047, rd, err);
        chk({31'h0, err}, 32'h1);
        apb(1'h0, 12'h1A0, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        rd_chk(32'h0000_0018);
        // Loader: negotiation off and half duplex, then negotiation on and full duplex
        reload(5'b00100);
        rd_chk(32'h0000_0021);
        reload(5'b11011);
        rd_chk(32'h0000_005E);
        // Negotiation off, manual clear: enables apply, negotiated pause ignored
        reload(5'b00001);
        rd_chk(32'h0000_0000);
        // Second reset with other strap levels
        bp_s <= 1'h0;
        man_s <= 1'h1;
        an_s <= 1'h0;
        resetn <= 1'h0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'h1;
        repeat (6) @(posedge sys_clk);
        rd_chk(32'h0000_001F);
        report_and_stop();
    end
endmodule
